// [common/alarm_relay_pkg.sv]
// constants, field layouts and carrier types of the alarm and relay block
// assumes one 100 MHz clock shared by the reading source and the register port
package alarm_relay_pkg;

  localparam int DATA_W   = 24;
  localparam int ADDR_W   = 8;
  localparam int BUS_W    = 32;
  localparam int LIN_FRAC = 12;
  localparam int N_IN     = 2;
  localparam int N_RELAY  = 2;

  // per input block, input B sits at IN_STRIDE above input A
  localparam logic [ADDR_W-1:0] IN_STRIDE  = 8'h20;
  localparam logic [2:0]        SUB_CFG    = 3'h0;
  localparam logic [2:0]        SUB_LOSP   = 3'h1;
  localparam logic [2:0]        SUB_HISP   = 3'h2;
  localparam logic [2:0]        SUB_DBAND  = 3'h3;
  localparam logic [2:0]        SUB_SLOPE  = 3'h4;
  localparam logic [2:0]        SUB_OFFSET = 3'h5;
  localparam logic [2:0]        SUB_VALUE  = 3'h6;
  localparam logic [ADDR_W-1:0] REG_RELAY  = 8'h40;
  localparam logic [ADDR_W-1:0] REG_AUDIO  = 8'h44;
  localparam logic [ADDR_W-1:0] REG_CLEAR  = 8'h48;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h4c;

  // input config fields
  localparam int CFG_W        = 11;
  localparam int CFG_EN       = 0;
  localparam int CFG_LATCH    = 1;
  localparam int CFG_SRC      = 2;
  localparam int CFG_FILT     = 4;
  localparam int CFG_SHIFT    = 5;
  localparam int CFG_LINEQ    = 8;
  localparam int CFG_LINX     = 9;
  localparam logic [CFG_W-1:0]  CFG_RST    = 11'h000;
  localparam logic [7:0]        RELAY_RST  = 8'h00;
  localparam logic [DATA_W-1:0] VAL_RST    = 24'h000000;
  localparam logic [DATA_W-1:0] SLOPE_RST  = 24'h001000;

  // status word fields
  localparam int ST_LOW    = 0;
  localparam int ST_HIGH   = 2;
  localparam int ST_RELAY  = 4;
  localparam int ST_BEEP   = 6;
  localparam int ST_LAMP   = 7;

  // annunciator flash half period
  localparam int CLK_MHZ        = 100;
  localparam int FLASH_HALF_MS  = 500;
  localparam int FLASH_HALF_CYC = FLASH_HALF_MS * 1000 * CLK_MHZ;

  typedef enum logic [1:0] {SRC_CELSIUS, SRC_KELVIN, SRC_LINEAR, SRC_SENSOR} src_e;
  typedef enum logic [1:0] {LX_CELSIUS, LX_KELVIN, LX_SENSOR, LX_SPARE} lin_x_e;
  typedef enum logic [1:0] {RLY_OFF, RLY_ON, RLY_FOLLOW_A, RLY_FOLLOW_B} relay_mode_e;
  typedef enum logic [1:0] {FN_LOW, FN_HIGH, FN_BOTH, FN_SPARE} relay_fn_e;

  typedef struct packed {
    logic signed [DATA_W-1:0] celsius;
    logic signed [DATA_W-1:0] kelvin;
    logic signed [DATA_W-1:0] sensor;
  } reading_s;

endpackage

// [design/alarm_relay_logic.sv]
// alarm comparison, annunciator, beeper and two-relay routing
// assumes readings and their valid strobes come from logic on clk
`timescale 1ns/1ns
`default_nettype none

//////////////////////////////////////////////////////////////////////////////
// Contract
// (R1) separate low and high alarm, own setpoints
// (R2) high alarm when reading exceeds high setpoint
// (R3) low alarm when reading below low setpoint
// (R4) lamp steady if enabled, flashing if active
// (R5) lamp uses both inputs, displayed or not
// (R6) beeper on active alarm if audible set
// (R7) latched alarm held until clear request
// (R8) non-latching alarm follows reading with hysteresis
// (R9) high releases at setpoint minus dead band
// (R10) low releases at setpoint plus dead band
// (R11) disabled input raises no alarms
// (R12) alarm source: celsius, kelvin, linear, sensor
// (R13) per-input latching select
// (R14) two relays: off, on, follow A, B
// (R15) forced off holds relay inactive
// (R16) forced on holds relay active
// (R17) following relay uses low, high, both select
// (R18) both: relay on for either alarm
// (R19) low or high only: that alarm alone
// (R20) relay two identical, independently configured
// (R21) filtered readings feed alarms when enabled
// (R22) linear: slope times reading plus offset variants
// (R23) reset clears alarms, relays inactive
// (R24) cleared alarm re-asserts on next reading
module alarm_relay_logic
  import alarm_relay_pkg::*;
#(
  parameter int FLASH_HALF = FLASH_HALF_CYC
)(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // register port
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [BUS_W-1:0]  regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [BUS_W-1:0]  regRdata,
  // sensor readings
  input  wire reading_s          sensorRead [N_IN],
  input  wire logic [N_IN-1:0]   readValid,
  // alarm outputs
  output logic      [N_IN-1:0]   alarmLow,
  output logic      [N_IN-1:0]   alarmHigh,
  output logic                   alarmLamp,
  output logic                   beeper,
  // relay drive
  output logic  [N_RELAY-1:0]    relayOn
);

  //////////////////////////////////////////////////////////////////////////////
  // configuration registers

  logic        [CFG_W-1:0]  cfg_r    [N_IN];
  logic signed [DATA_W-1:0] loSp_r   [N_IN];
  logic signed [DATA_W-1:0] hiSp_r   [N_IN];
  logic signed [DATA_W-1:0] dband_r  [N_IN];
  logic signed [DATA_W-1:0] slope_r  [N_IN];
  logic signed [DATA_W-1:0] offset_r [N_IN];
  logic signed [DATA_W-1:0] val_r    [N_IN];
  logic        [7:0]        relayCfg_r;
  logic                     audible_r;
  logic                     clearReq;
  logic                     inSel;
  logic        [2:0]        subSel;
  logic                     inHit;
  logic        [BUS_W-1:0]  rdNxt;
  logic        [BUS_W-1:0]  statusWord;
  logic        [BUS_W-1:0]  rdata_r;

  assign inSel  = regAddr[5];
  assign subSel = regAddr[4:2];
  assign inHit  = (regAddr[ADDR_W-1:6] == 2'b00) && (regAddr[1:0] == 2'b00);

  // alarm-key action: one write pulse clears every latched alarm
  assign clearReq = regWr && (regAddr == REG_CLEAR) && regWdata[0];

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < N_IN; i++)
      begin
        cfg_r[i]    <= CFG_RST;
        loSp_r[i]   <= VAL_RST;
        hiSp_r[i]   <= VAL_RST;
        dband_r[i]  <= VAL_RST;
        slope_r[i]  <= SLOPE_RST;
        offset_r[i] <= VAL_RST;
      end
    end
    else if (regWr && inHit)
    begin
      // (R1) own setpoints per input
      case (subSel)
        SUB_CFG:    cfg_r[inSel]    <= regWdata[CFG_W-1:0];
        SUB_LOSP:   loSp_r[inSel]   <= regWdata[DATA_W-1:0];
        SUB_HISP:   hiSp_r[inSel]   <= regWdata[DATA_W-1:0];
        SUB_DBAND:  dband_r[inSel]  <= regWdata[DATA_W-1:0];
        SUB_SLOPE:  slope_r[inSel]  <= regWdata[DATA_W-1:0];
        SUB_OFFSET: offset_r[inSel] <= regWdata[DATA_W-1:0];
        default:    ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      relayCfg_r <= RELAY_RST;
      audible_r  <= 1'b0;
    end
    else if (regWr)
    begin
      if (regAddr == REG_RELAY)
      begin
        relayCfg_r <= regWdata[7:0];
      end
      // (R6) one audible setting for all alarms
      if (regAddr == REG_AUDIO)
      begin
        audible_r <= regWdata[0];
      end
    end
  end

  assign statusWord = {{(BUS_W-8){1'b0}}, alarmLamp, beeper, relayOn, alarmHigh, alarmLow};

  always_comb
  begin
    rdNxt = '0;
    if (inHit)
    begin
      case (subSel)
        SUB_CFG:    rdNxt = {{(BUS_W-CFG_W){1'b0}}, cfg_r[inSel]};
        SUB_LOSP:   rdNxt = BUS_W'(loSp_r[inSel]);
        SUB_HISP:   rdNxt = BUS_W'(hiSp_r[inSel]);
        SUB_DBAND:  rdNxt = BUS_W'(dband_r[inSel]);
        SUB_SLOPE:  rdNxt = BUS_W'(slope_r[inSel]);
        SUB_OFFSET: rdNxt = BUS_W'(offset_r[inSel]);
        SUB_VALUE:  rdNxt = BUS_W'(val_r[inSel]);
        default:    rdNxt = '0;
      endcase
    end
    else if (regAddr == REG_RELAY)
    begin
      rdNxt = {{(BUS_W-8){1'b0}}, relayCfg_r};
    end
    else if (regAddr == REG_AUDIO)
    begin
      rdNxt = {{(BUS_W-1){1'b0}}, audible_r};
    end
    else if (regAddr == REG_STATUS)
    begin
      rdNxt = statusWord;
    end
  end

  // read data stand for one cycle only, zero otherwise
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rdata_r <= '0;
    end
    else
    begin
      rdata_r <= regRd ? rdNxt : '0;
    end
  end

  assign regRdata = rdata_r;

  //////////////////////////////////////////////////////////////////////////////
  // per input reading path and alarm state

  logic [N_IN-1:0] upd_r;
  logic [N_IN-1:0] primed_r;
  logic [N_IN-1:0] lo_r;
  logic [N_IN-1:0] hi_r;

  for (genvar g = 0; g < N_IN; g++)
  begin : gIn
    logic signed [DATA_W-1:0]   linX;
    logic signed [DATA_W:0]     linOpnd;
    logic signed [2*DATA_W:0]   linProd;
    logic signed [2*DATA_W:0]   linShift;
    logic signed [DATA_W-1:0]   linVal;
    logic signed [DATA_W-1:0]   rawVal;
    logic signed [DATA_W:0]     diff;
    logic signed [DATA_W:0]     step;
    logic        [2:0]          shamt;
    logic signed [DATA_W:0]     cur;
    logic signed [DATA_W:0]     hiTrip;
    logic signed [DATA_W:0]     hiHold;
    logic signed [DATA_W:0]     loTrip;
    logic signed [DATA_W:0]     loHold;
    logic                       hiCond;
    logic                       loCond;
    logic                       en;
    logic                       latch;

    assign en    = cfg_r[g][CFG_EN];
    assign latch = cfg_r[g][CFG_LATCH];

    always_comb
    begin
      case (lin_x_e'(cfg_r[g][CFG_LINX +: 2]))
        LX_CELSIUS: linX = sensorRead[g].celsius;
        LX_KELVIN:  linX = sensorRead[g].kelvin;
        default:    linX = sensorRead[g].sensor;
      endcase
    end

    // (R22) equation select: offset added before or after scaling
    assign linOpnd  = cfg_r[g][CFG_LINEQ] ? (DATA_W+1)'(linX) + (DATA_W+1)'(offset_r[g])
                                          : (DATA_W+1)'(linX);
    assign linProd  = (2*DATA_W+1)'(slope_r[g]) * (2*DATA_W+1)'(linOpnd);
    assign linShift = linProd >>> LIN_FRAC;
    // wraps on overflow; slope and offset are expected to keep the result in range
    assign linVal   = cfg_r[g][CFG_LINEQ] ? linShift[DATA_W-1:0]
                                          : linShift[DATA_W-1:0] + offset_r[g];

    // (R12) alarm source select
    always_comb
    begin
      case (src_e'(cfg_r[g][CFG_SRC +: 2]))
        SRC_CELSIUS: rawVal = sensorRead[g].celsius;
        SRC_KELVIN:  rawVal = sensorRead[g].kelvin;
        SRC_LINEAR:  rawVal = linVal;
        default:     rawVal = sensorRead[g].sensor;
      endcase
    end

    // running average keeps the update rate; shift 0 behaves as 1
    assign shamt = (cfg_r[g][CFG_SHIFT +: 3] == 3'h0) ? 3'h1 : cfg_r[g][CFG_SHIFT +: 3];
    assign diff  = (DATA_W+1)'(rawVal) - (DATA_W+1)'(val_r[g]);
    assign step  = diff >>> shamt;

    // (R21) filtered value drives the alarms
    always_ff @(posedge clk or posedge sys_rst)
    begin
      if (sys_rst)
      begin
        val_r[g]    <= VAL_RST;
        primed_r[g] <= 1'b0;
        upd_r[g]    <= 1'b0;
      end
      else
      begin
        upd_r[g] <= readValid[g];
        if (readValid[g])
        begin
          primed_r[g] <= cfg_r[g][CFG_FILT];
          if (cfg_r[g][CFG_FILT] && primed_r[g])
          begin
            val_r[g] <= val_r[g] + step[DATA_W-1:0];
          end
          else
          begin
            val_r[g] <= rawVal;
          end
        end
      end
    end

    // one extra bit so setpoint plus dead band cannot wrap
    assign cur    = (DATA_W+1)'(val_r[g]);
    assign hiTrip = (DATA_W+1)'(hiSp_r[g]);
    assign loTrip = (DATA_W+1)'(loSp_r[g]);
    // (R9) high release threshold
    assign hiHold = hiTrip - (DATA_W+1)'(dband_r[g]);
    // (R10) low release threshold
    assign loHold = loTrip + (DATA_W+1)'(dband_r[g]);
    // (R2) above high setpoint, held above release point
    assign hiCond = hi_r[g] ? (cur > hiHold) : (cur > hiTrip);
    // (R3) below low setpoint, held below release point
    assign loCond = lo_r[g] ? (cur < loHold) : (cur < loTrip);

    always_ff @(posedge clk or posedge sys_rst)
    begin
      // (R23) alarms start cleared
      if (sys_rst)
      begin
        hi_r[g] <= 1'b0;
        lo_r[g] <= 1'b0;
      end
      // (R11) disabled input holds no alarms
      else if (!en)
      begin
        hi_r[g] <= 1'b0;
        lo_r[g] <= 1'b0;
      end
      else if (upd_r[g])
      begin
        // (R13) latch select
        if (latch)
        begin
          // (R7) held until cleared; a new trip beats a same-cycle clear
          hi_r[g] <= (hi_r[g] && !clearReq) || hiCond;
          lo_r[g] <= (lo_r[g] && !clearReq) || loCond;
        end
        else
        begin
          // (R8) follows the reading
          hi_r[g] <= hiCond;
          lo_r[g] <= loCond;
        end
      end
      // (R24) cleared here, next reading sets it again if still met
      else if (clearReq && latch)
      begin
        hi_r[g] <= 1'b0;
        lo_r[g] <= 1'b0;
      end
    end
  end

  assign alarmLow  = lo_r;
  assign alarmHigh = hi_r;

  //////////////////////////////////////////////////////////////////////////////
  // annunciator and beeper

  logic [31:0] flashCnt_r;
  logic        flash_r;
  logic        lamp_r;
  logic        beep_r;
  logic        anyEn;
  logic        anyAct;

  // (R5) both inputs count, no display dependency
  always_comb
  begin
    anyEn  = 1'b0;
    anyAct = 1'b0;
    for (int i = 0; i < N_IN; i++)
    begin
      anyEn  = anyEn | cfg_r[i][CFG_EN];
      anyAct = anyAct | lo_r[i] | hi_r[i];
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      flashCnt_r <= '0;
      flash_r    <= 1'b0;
    end
    else if (flashCnt_r >= 32'(FLASH_HALF - 1))
    begin
      flashCnt_r <= '0;
      flash_r    <= !flash_r;
    end
    else
    begin
      flashCnt_r <= flashCnt_r + 32'h00000001;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      lamp_r <= 1'b0;
      beep_r <= 1'b0;
    end
    else
    begin
      // (R4) steady when enabled, flashing when active
      lamp_r <= anyEn && (anyAct ? flash_r : 1'b1);
      // (R6) beeper gated by audible setting
      beep_r <= audible_r && anyAct;
    end
  end

  assign alarmLamp = lamp_r;
  assign beeper    = beep_r;

  //////////////////////////////////////////////////////////////////////////////
  // relays

  logic [N_RELAY-1:0] relay_r;

  // (R20) every relay built from the same logic, own field pair
  for (genvar r = 0; r < N_RELAY; r++)
  begin : gRelay
    relay_mode_e mode;
    relay_fn_e   fn;
    logic        followLo;
    logic        followHi;
    logic        drive;

    assign mode = relay_mode_e'(relayCfg_r[4*r +: 2]);
    assign fn   = relay_fn_e'(relayCfg_r[4*r+2 +: 2]);

    always_comb
    begin
      followLo = 1'b0;
      followHi = 1'b0;
      drive    = 1'b0;
      // (R14) mode select
      case (mode)
        RLY_FOLLOW_A:
        begin
          followLo = lo_r[0];
          followHi = hi_r[0];
        end
        RLY_FOLLOW_B:
        begin
          followLo = lo_r[1];
          followHi = hi_r[1];
        end
        default:
        begin
          followLo = 1'b0;
          followHi = 1'b0;
        end
      endcase
      case (mode)
        // (R15) forced off
        RLY_OFF: drive = 1'b0;
        // (R16) forced on
        RLY_ON:  drive = 1'b1;
        default:
        begin
          // (R17) function select on followed input
          case (fn)
            // (R19) single alarm only
            FN_LOW:  drive = followLo;
            FN_HIGH: drive = followHi;
            // (R18) either alarm
            default: drive = followLo | followHi;
          endcase
        end
      endcase
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
      // (R23) relays inactive from reset
      if (sys_rst)
      begin
        relay_r[r] <= 1'b0;
      end
      else
      begin
        relay_r[r] <= drive;
      end
    end
  end

  assign relayOn = relay_r;

endmodule

`default_nettype wire

// [tb/alarm_relay_asserts.sv]
// timing checks on the alarm and relay outputs
// assumes a bind onto alarm_relay_logic, one clock, async reset
`timescale 1ns/1ns
`default_nettype none
module alarm_relay_asserts
  import alarm_relay_pkg::*;
#(
  parameter int FLASH_HALF = 4
)(
  // clock and reset
  input wire logic               clk,
  input wire logic               sys_rst,
  // causes
  input wire logic               regWr,
  input wire logic [N_IN-1:0]    readValid,
  // watched outputs
  input wire logic [N_IN-1:0]    alarmLow,
  input wire logic [N_IN-1:0]    alarmHigh,
  input wire logic               alarmLamp,
  input wire logic               beeper,
  input wire logic [N_RELAY-1:0] relayOn
);
  logic [2*N_IN-1:0] alD;
  logic [2*N_IN-1:0] alD2;
  logic              lampD;
  logic              anyAl;
  int                cnt;

  assign anyAl = |{alarmLow, alarmHigh};

  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      alD <= '0;
      alD2 <= '0;
      lampD <= 1'b0;
      cnt <= 0;
    end
    else
    begin
      alD <= {alarmLow, alarmHigh};
      alD2 <= alD;
      lampD <= alarmLamp;
      // a stuck lamp under alarm shows as a long run
      cnt <= (anyAl && alarmLamp == lampD) ? cnt + 1 : 0;
    end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  //////////////////////////////////////////////////////////////////////////////
  reset_quiet_a: assert property (disable iff (1'b0)
    sys_rst |-> !alarmLow && !alarmHigh && !relayOn && !beeper && !alarmLamp)
    else $error("outputs active in reset");
  high_by_read_a: assert property (
    ((alarmHigh & ~$past(alarmHigh)) & ~$past(readValid, 2)) == '0)
    else $error("high alarm rose without reading");
  low_by_read_a: assert property (
    ((alarmLow & ~$past(alarmLow)) & ~$past(readValid, 2)) == '0)
    else $error("low alarm rose without reading");
  alarm_hold_a: assert property (
    {alarmLow, alarmHigh} != alD |-> $past(readValid, 2) != '0 || $past(regWr)
      || $past(regWr, 2))
    else $error("alarm changed with no cause");
  relay_cause_a: assert property (
    $changed(relayOn) |-> alD != alD2 || $past(regWr) || $past(regWr, 2))
    else $error("relay changed with no cause");
  beep_cause_a: assert property (
    beeper |-> alD != '0)
    else $error("beeper without alarm");
  lamp_flash_a: assert property (
    cnt <= FLASH_HALF + 2)
    else $error("lamp not flashing under alarm");
  lamp_fall_a: assert property (
    $fell(alarmLamp) |-> $past(anyAl) || $past(anyAl, 2) || $past(regWr, 2)
      || $past(regWr, 3))
    else $error("lamp dropped with no cause");

  cover property (alarmHigh[0] && relayOn[0]);
  cover property (alarmLow[1] && beeper);
  cover property ($fell(alarmLamp) && anyAl);
endmodule
`default_nettype wire

// [tb/sensor_model.sv]
// reading source for both inputs
// assumes the bench requests one reading per go pulse
`timescale 1ns/1ns
`default_nettype none
module sensor_model
  import alarm_relay_pkg::*;
(
  // request from bench
  input wire logic      clk,
  input wire logic      go,
  input wire logic      idx,
  input wire reading_s  val,
  // readings out
  output var reading_s    sensorRead [N_IN],
  output var logic [N_IN-1:0] readValid
);
  initial
  begin
    readValid = '0;
    sensorRead = '{default: '0};
  end

  always @(posedge clk)
  begin
    readValid <= '0;
    // stale values inverted so nothing leans on them
    for (int i = 0; i < N_IN; i++)
      sensorRead[i] <= ~sensorRead[i];
    if (go)
    begin
      readValid[idx] <= 1'b1;
      sensorRead[idx] <= val;
    end
  end
endmodule
`default_nettype wire

// [tb/testbench.sv]
// self-checking bench for alarm_relay_logic
// assumes register port and readings share clk
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import alarm_relay_pkg::*;
  logic              clk = 0;
  logic              sys_rst;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [BUS_W-1:0]  regWdata = '0;
  logic              regWr = 0;
  logic              regRd = 0;
  logic              go = 0;
  logic              idx = 0;
  reading_s          val = '0;
  reading_s          sensorRead [N_IN];
  logic [N_IN-1:0]   readValid, alarmLow, alarmHigh;
  logic [1:0]        relayOn;
  logic [BUS_W-1:0]  regRdata, d;
  logic              alarmLamp, beeper;
  int                errors = 0, checks = 0, cyc = 0, v, r, i;
  int                lo[2], hi[2], db[2], src[2], sl[2] = '{2, 1}, of[2] = '{10, 0};
  bit                en[2], lat[2], eq[2], aud;
  bit [1:0]          aL, aH;
  bit [7:0]          rc;

  alarm_relay_logic #(.FLASH_HALF(4)) alarm_relay_logic_i (.clk, .sys_rst, .regAddr,
    .regWdata, .regWr, .regRd, .regRdata, .sensorRead, .readValid, .alarmLow,
    .alarmHigh, .alarmLamp, .beeper, .relayOn);
  sensor_model sensor_model_i (.clk, .go, .idx, .val, .sensorRead, .readValid);

  initial forever #5 clk = ~clk;
  always @(posedge clk)
    if (++cyc == 10000)
    begin
      errors++;
      wrap_up();
    end

  //////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    if (errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    @(posedge clk);
    regAddr <= a;
    regWdata <= w;
    regWr <= 1;
    @(posedge clk);
    regWr <= 0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1;
    @(posedge clk);
    regRd <= 0;
    #1 q = regRdata;
  endtask
  function automatic bit rly(bit [3:0] c);
    if (c[1:0] < 2) return c[0];
    return c[3:2] == 0 ? aL[c[0]] : c[3:2] == 1 ? aH[c[0]] : aL[c[0]] | aH[c[0]];
  endfunction
  task automatic cmp;
    chk(alarmLow, aL);
    chk(alarmHigh, aH);
    chk(relayOn, {rly(rc[7:4]), rly(rc[3:0])});
    chk(beeper, aud & |{aL, aH});
  endtask
  task automatic cfgw(input int n);
    wr(8'(n * 32), 32'(en[n]) | 32'(lat[n]) << CFG_LATCH | 32'(src[n]) << CFG_SRC
      | 32'(eq[n]) << CFG_LINEQ);
    if (!en[n]) aL[n] = 0;
    if (!en[n]) aH[n] = 0;
  endtask
  task automatic rdg(input int n, input int c);
    int x;
    int lin;
    @(posedge clk);
    val <= '{24'(c), 24'(c + 7), 24'(-c)};
    idx <= n[0];
    go <= 1;
    @(posedge clk);
    go <= 0;
    lin = eq[n] ? sl[n] * (c + of[n]) : sl[n] * c + of[n];
    x = src[n] == 0 ? c : src[n] == 1 ? c + 7 : src[n] == 2 ? lin : -c;
    if (en[n]) aH[n] = x > hi[n] || (aH[n] && (lat[n] || x > hi[n] - db[n]));
    if (en[n]) aL[n] = x < lo[n] || (aL[n] && (lat[n] || x < lo[n] + db[n]));
    repeat (3) @(posedge clk);
    #1 cmp();
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    // a real rising edge on reset, so the async branch runs before any check samples
    sys_rst = 1'b1;
    void'($urandom(32'h4662));
    lo = '{-100, -20};
    hi = '{100, 30};
    db = '{5, 3};
    repeat (10) @(posedge clk);
    sys_rst <= 0;
    rd(8'h00, d);
    chk(d, CFG_RST);
    rd(8'h30, d);
    chk(d, SLOPE_RST);
    wr(8'h3c, '1);
    rd(8'h3c, d);
    chk(d, 0);
    for (i = 0; i < 2; i++)
    begin
      wr(8'(i * 32 + 4), 32'(lo[i]));
      wr(8'(i * 32 + 8), 32'(hi[i]));
      wr(8'(i * 32 + 12), 32'(db[i]));
    end
    wr(8'h10, 32'h2000);
    wr(8'h14, 32'(10));
    rd(8'h04, d);
    chk(d, 32'hffffff9c);
    // random sources, relay modes and readings
    for (int n = 0; n < 90; n++)
    begin
      if (n % 6 == 0)
        for (i = 0; i < 2; i++)
        begin
          en[i] = $urandom % 5 != 0;
          src[i] = $urandom % 4;
          eq[i] = $urandom % 2;
          cfgw(i);
        end
      if (n % 6 == 0) rc = $urandom;
      if (n % 6 == 0) wr(REG_RELAY, rc);
      aud = $urandom % 2;
      wr(REG_AUDIO, aud);
      i = $urandom % 2;
      r = i ? 45 : 130;
      v = $urandom_range(2 * r) - r;
      rdg(i, v);
    end
    // latched high on A, live low on B
    en = '{1, 1};
    lat = '{1, 0};
    src = '{0, 0};
    cfgw(0);
    cfgw(1);
    rdg(0, 150);
    rdg(1, -30);
    rdg(0, 0);
    for (int j = 0; j < 16; j++)
    begin
      rc = {4'(15 - j), 4'(j)};
      wr(REG_RELAY, rc);
      repeat (3) @(posedge clk);
      #1 cmp();
    end
    rd(REG_STATUS, d);
    chk(d[6:0], {aud & |{aL, aH}, rly(rc[7:4]), rly(rc[3:0]), aH, aL});
    // clear hits only the latched input
    wr(REG_CLEAR, 1);
    aL[0] = 0;
    aH[0] = 0;
    @(posedge clk);
    #1 cmp();
    rdg(0, 150);
    en = '{0, 0};
    cfgw(0);
    cfgw(1);
    repeat (3) @(posedge clk);
    #1 cmp();
    chk(alarmLamp, 0);
    en[1] = 1;
    cfgw(1);
    rdg(1, 0);
    repeat (10)
    begin
      @(posedge clk);
      #1 chk(alarmLamp, 1);
    end
    // filter on B, shift 1: first reading loads, next moves half way
    wr(8'h20, 32'h00000031);
    rdg(1, 0);
    rdg(1, 20);
    rd(8'h38, d);
    chk(d, 10);
    wrap_up();
  end
endmodule

bind alarm_relay_logic alarm_relay_asserts #(.FLASH_HALF(FLASH_HALF)) ar_chk (.clk(clk),
  .sys_rst(sys_rst), .regWr(regWr), .readValid(readValid), .alarmLow(alarmLow),
  .alarmHigh(alarmHigh), .alarmLamp(alarmLamp), .beeper(beeper), .relayOn(relayOn));
`default_nettype wire
